// ---- core/adc_accumulate_powerup_ctrl.sv ----
module adc_accumulate_powerup_ctrl
    import adc_acc_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input  wire logic              clk_i,                // System clock
    input  wire logic              sys_rst_i,            // Async reset, high
    input  wire logic              ce_i,                 // Clock enable
    input  wire logic [7:0]        sfr_addr_i,           // Register address
    input  wire logic              sfr_wr_i,             // Register write strobe
    input  wire logic [7:0]        sfr_wdata_i,          // Write data
    output logic      [7:0]        sfr_rdata_o,          // Read data, one cycle late
    input  wire logic              burst_operation_enable_i, // Burst mode on
    input  wire logic              converter_enable_i,   // Converter enable
    input  wire logic              soc_i,                // Start of conversion pulse
    input  wire conv_result_s      conv_i,               // Conversion done and data
    output logic                   wide_mode_enable_o,   // 12-bit mode select
    output logic                   low_power_mode_enable_o, // Low power mode
    output logic                   converter_power_o,    // Converter powered
    output logic                   conv_go_o,            // Conversion may proceed
    output logic                   burst_busy_o,         // Burst in progress
    output logic      [15:0]       result_o              // Running total
);

    typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_RUN} burst_state_e;

    acc_cfg_s     acc_cfg;
    pwr_cfg_s     pwr_cfg;
    burst_state_e state;
    logic [15:0]  total;
    logic [8:0]   wake_cnt;
    logic [6:0]   conv_cnt;
    logic [6:0]   rpt_n;
    logic [15:0]  view;
    logic [15:0]  next_total;
    logic         wr_cfg;
    logic         wr_pwr;
    logic         wr_lo;
    logic         wr_hi;
    logic         last_conv;

    assign wr_cfg = ce_i && sfr_wr_i && (sfr_addr_i == ACC_CFG_ADDR);
    assign wr_pwr = ce_i && sfr_wr_i && (sfr_addr_i == PWR_TIME_ADDR);
    assign wr_lo  = ce_i && sfr_wr_i && (sfr_addr_i == RESULT_LO_ADDR);
    assign wr_hi  = ce_i && sfr_wr_i && (sfr_addr_i == RESULT_HI_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_cfg <= acc_cfg_s'(ACC_CFG_RESET);
        end else if (wr_cfg) begin
            acc_cfg.wide  <= sfr_wdata_i[WIDE_BIT];
            acc_cfg.accum <= sfr_wdata_i[ACCUM_BIT];
            acc_cfg.sj    <= sfr_wdata_i[SJ_LSB +: 3];
            acc_cfg.rpt   <= sfr_wdata_i[RPT_LSB +: 3];
        end
    end

    // Power-up timing register; unused bits 6:4 are not stored
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwr_cfg <= '{lpm: PWR_TIME_RESET[LPM_BIT], pwr: PWR_TIME_RESET[PWR_LSB +: 4]};
        end else if (wr_pwr) begin
            pwr_cfg.lpm <= sfr_wdata_i[LPM_BIT];
            pwr_cfg.pwr <= sfr_wdata_i[PWR_LSB +: 4];
        end
    end

    assign wide_mode_enable_o      = acc_cfg.wide;
    assign low_power_mode_enable_o = pwr_cfg.lpm;

    ////////////////////////////////////////////////////////////////////////////////
    // Repeat code decode; reserved codes fall back to a single conversion
    always_comb begin
        unique case (acc_cfg.rpt)
            3'h1:    rpt_n = 7'd4;
            3'h2:    rpt_n = 7'd8;
            3'h3:    rpt_n = 7'd16;
            3'h4:    rpt_n = 7'd32;
            3'h5:    rpt_n = 7'd64;
            default: rpt_n = 7'd1;
        endcase
    end

    assign last_conv = (conv_cnt == rpt_n - 7'd1);

    ////////////////////////////////////////////////////////////////////////////////
    // Burst sequencer: wake delay only when the converter was allowed to sleep
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state    <= ST_IDLE;
            wake_cnt <= '0;
            conv_cnt <= '0;
        end else if (ce_i) begin
            unique case (state)
                ST_IDLE: begin
                    conv_cnt <= '0;
                    if (burst_operation_enable_i && soc_i) begin
                        if (converter_enable_i) begin
                            state <= ST_RUN;
                        end else begin
                            state    <= ST_WAKE;
                            wake_cnt <= 9'((32'(pwr_cfg.pwr) + 1) * PWR_STEP_CYC - 1);
                        end
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt == '0) begin
                        state <= ST_RUN;
                    end else begin
                        wake_cnt <= wake_cnt - 9'd1;
                    end
                end
                ST_RUN: begin
                    if (conv_i.done) begin
                        conv_cnt <= conv_cnt + 7'd1;
                        if (last_conv) begin
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Leaving burst mode does not stop a sequence; the sequencer runs on to its next idle visit
    assign burst_busy_o = (state != ST_IDLE);
    // Burst with enable set never sleeps; burst with enable clear sleeps outside a burst; burst off follows the enable
    assign converter_power_o = burst_operation_enable_i ?
                               (converter_enable_i || state != ST_IDLE)
                               : converter_enable_i;
    assign conv_go_o = burst_operation_enable_i ? (state == ST_RUN)
                                                : converter_enable_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Running total; a finished conversion beats a software write in the same cycle, unless burst mode drops it outside ST_RUN
    always_comb begin
        next_total = total;
        if (wr_lo) begin
            next_total[7:0] = sfr_wdata_i;
        end
        if (wr_hi) begin
            next_total[15:8] = sfr_wdata_i;
        end
        if (conv_i.done) begin
            if (burst_operation_enable_i) begin
                if (state == ST_RUN) begin
                    next_total = (conv_cnt == '0) ? 16'(conv_i.data)
                                                  : total + 16'(conv_i.data);
                end
            end else if (acc_cfg.accum) begin
                next_total = total + 16'(conv_i.data);
            end else begin
                next_total = 16'(conv_i.data);
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            total <= '0;
        end else if (ce_i) begin
            total <= next_total;
        end
    end

    assign result_o = total;

    ////////////////////////////////////////////////////////////////////////////////
    // Read view: shifting here keeps the stored sum exact
    always_comb begin
        view = total;
        if (acc_cfg.sj == SJ_LEFT) begin
            view = acc_cfg.wide ? (total << (16 - WIDE_BITS))
                                : (total << (16 - NARROW_BITS));
        end else if (!acc_cfg.sj[2]) begin
            view = total >> acc_cfg.sj;
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= '0;
        end else if (ce_i) begin
            unique case (sfr_addr_i)
                ACC_CFG_ADDR:   sfr_rdata_o <= {acc_cfg.wide, 1'b0,
                                                acc_cfg.sj, acc_cfg.rpt};
                PWR_TIME_ADDR:  sfr_rdata_o <= {pwr_cfg.lpm, 3'h0, pwr_cfg.pwr};
                RESULT_LO_ADDR: sfr_rdata_o <= view[7:0];
                RESULT_HI_ADDR: sfr_rdata_o <= view[15:8];
                default:        sfr_rdata_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_wide;
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_cfg |=> (wide_mode_enable_o == $past(sfr_wdata_i[WIDE_BIT]));
    endproperty
    a_wide: assert property (p_wide) else $error("wide mode not taken");

    property p_latest;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && conv_i.done && !burst_operation_enable_i && !acc_cfg.accum
        |=> (total == 16'($past(conv_i.data)));
    endproperty
    a_latest: assert property (p_latest) else $error("latest result not held");

    property p_accum;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && conv_i.done && !burst_operation_enable_i && acc_cfg.accum
        |=> (total == $past(total) + 16'($past(conv_i.data)));
    endproperty
    a_accum: assert property (p_accum) else $error("result not accumulated");

    property p_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_hi && sfr_wdata_i == 8'h00 && !conv_i.done |=> (total[15:8] == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("high byte not cleared");

    property p_ae_read;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && sfr_addr_i == ACC_CFG_ADDR |=> !sfr_rdata_o[ACCUM_BIT];
    endproperty
    a_ae_read: assert property (p_ae_read) else $error("accumulate bit read back");

    property p_left;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && sfr_addr_i == RESULT_LO_ADDR && acc_cfg.sj == SJ_LEFT && acc_cfg.wide
        |=> (sfr_rdata_o[3:0] == 4'h0);
    endproperty
    a_left: assert property (p_left) else $error("left justify wrong");

    property p_count;
        @(posedge clk_i) disable iff (sys_rst_i)
        state == ST_RUN |-> (conv_cnt < rpt_n);
    endproperty
    a_count: assert property (p_count) else $error("burst count overrun");

    property p_nburst;
        @(posedge clk_i) disable iff (sys_rst_i)
        !burst_operation_enable_i |-> (converter_power_o == converter_enable_i);
    endproperty
    a_nburst: assert property (p_nburst) else $error("power not tracking enable");

    property p_stay;
        @(posedge clk_i) disable iff (sys_rst_i)
        burst_operation_enable_i && converter_enable_i |-> converter_power_o;
    endproperty
    a_stay: assert property (p_stay) else $error("converter dropped power");

    property p_wait;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && state == ST_IDLE && soc_i && burst_operation_enable_i && !converter_enable_i
        |=> !conv_go_o [*8];
    endproperty
    a_wait: assert property (p_wait) else $error("conversion before wake delay");

endmodule

// ---- shared/adc_acc_pkg.sv ----
package adc_acc_pkg;

    // Register addresses on the 8-bit special function register port
    localparam logic [7:0] ACC_CFG_ADDR    = 8'hBA;
    localparam logic [7:0] PWR_TIME_ADDR   = 8'hBB;
    localparam logic [7:0] RESULT_LO_ADDR  = 8'hBD;
    localparam logic [7:0] RESULT_HI_ADDR  = 8'hBE;

    // Field positions
    localparam int WIDE_BIT  = 7;
    localparam int ACCUM_BIT = 6;
    localparam int SJ_LSB    = 3;
    localparam int RPT_LSB   = 0;
    localparam int LPM_BIT   = 7;
    localparam int PWR_LSB   = 0;

    // Reset values
    localparam logic [7:0] ACC_CFG_RESET  = 8'h00;
    localparam logic [7:0] PWR_TIME_RESET = 8'h0F;

    // Shift and justify codes
    localparam logic [2:0] SJ_LEFT = 3'h4;

    // Data width in each mode
    localparam int WIDE_BITS   = 12;
    localparam int NARROW_BITS = 10;

    // Power-up step time and its count in system clocks
    localparam int CLK_PERIOD_NS = 20;
    localparam int PWR_STEP_NS   = 400;
    localparam int PWR_STEP_CYC  = (PWR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic       wide;
        logic       accum;
        logic [2:0] sj;
        logic [2:0] rpt;
    } acc_cfg_s;

    typedef struct packed {
        logic       lpm;
        logic [3:0] pwr;
    } pwr_cfg_s;

    typedef struct packed {
        logic       done;
        logic [11:0] data;
    } conv_result_s;

endpackage

// ---- tb/tb_adc_accumulate_powerup_ctrl.sv ----
module tb_adc_accumulate_powerup_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_acc_pkg::*;

    logic         clk_i     = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic         ce        = 1'b1;
    logic         wr_en     = 1'b0;
    logic         burst     = 1'b0;
    logic         conv_en   = 1'b0;
    logic         soc       = 1'b0;
    logic [7:0]   addr      = 8'h00;
    logic [7:0]   wdata     = 8'h00;
    conv_result_s conv      = '0;
    logic [7:0]   rdata;
    logic         wide;
    logic         lpm;
    logic         pwr;
    logic         go;
    logic         busy;
    logic [15:0]  total;
    int           error_cnt = 0;
    int           n_checks  = 0;
    int           cnt[6]    = '{1, 4, 8, 16, 32, 64};

    ////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz
    always #10 clk_i = ~clk_i;

    adc_accumulate_powerup_ctrl i_dut (
        .clk_i                   (clk_i),
        .sys_rst_i               (sys_rst_i),
        .ce_i                    (ce),
        .sfr_addr_i              (addr),
        .sfr_wr_i                (wr_en),
        .sfr_wdata_i             (wdata),
        .sfr_rdata_o             (rdata),
        .burst_operation_enable_i(burst),
        .converter_enable_i      (conv_en),
        .soc_i                   (soc),
        .conv_i                  (conv),
        .wide_mode_enable_o      (wide),
        .low_power_mode_enable_o (lpm),
        .converter_power_o       (pwr),
        .conv_go_o               (go),
        .burst_busy_o            (busy),
        .result_o                (total)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counts, verdict and comparison
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register port: inputs move on falling edges only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk_i);
        wr_en = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        @(negedge clk_i);
        d = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        check({8'h00, d}, {8'h00, exp}, what);
    endtask

    task automatic conv1(input logic [11:0] d);
        @(negedge clk_i);
        conv.done = 1'b1;
        conv.data = d;
        @(negedge clk_i);
        conv.done = 1'b0;
    endtask

    // Bounded wait for go; a hang ends the run as a mismatch
    task automatic soc_wait(output int n);
        n = 0;
        @(negedge clk_i);
        soc = 1'b1;
        @(negedge clk_i);
        soc = 1'b0;
        while (go !== 1'b1) begin
            n++;
            if (n > 400) begin
                error_cnt++;
                $display("[FAIL] %0t go never rose", $time);
                give_verdict();
            end
            @(negedge clk_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int         n;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [2:0] code;
        logic       w;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        rchk(ACC_CFG_ADDR, 8'h00, "config reset");
        rchk(PWR_TIME_ADDR, 8'h0F, "power reg reset");
        rchk(8'hBC, 8'h00, "unmapped read");
        check(16'(lpm), 16'h0000, "lpm reset");
        wr(ACC_CFG_ADDR, 8'hC0);
        rchk(ACC_CFG_ADDR, 8'h80, "accumulate bit hidden");
        check(16'(wide), 16'h0001, "wide on");
        wr(ACC_CFG_ADDR, 8'h40);
        check(16'(wide), 16'h0000, "wide off");
        wr(PWR_TIME_ADDR, 8'hFF);
        rchk(PWR_TIME_ADDR, 8'h8F, "power reg fields");
        check(16'(lpm), 16'h0001, "lpm on");
        wr(PWR_TIME_ADDR, 8'h7F);
        check(16'(lpm), 16'h0000, "lpm off");
        $display("Test registers done");
        // Accumulate over a byte boundary, then clear both bytes
        conv1(12'hFFF);
        conv1(12'hFFF);
        check(total, 16'h1FFE, "accumulated sum");
        wr(RESULT_LO_ADDR, 8'h00);
        wr(RESULT_HI_ADDR, 8'h00);
        check(total, 16'h0000, "cleared sum");
        conv1(12'h003);
        check(total, 16'h0003, "sum from zero");
        wr(ACC_CFG_ADDR, 8'h00);
        conv1(12'h005);
        conv1(12'h3B5);
        check(total, 16'h03B5, "latest only");
        // Clock enable low: neither a conversion nor a write may land
        @(negedge clk_i);
        ce = 1'b0;
        conv1(12'h005);
        wr(ACC_CFG_ADDR, 8'h80);
        @(negedge clk_i);
        ce = 1'b1;
        check(total, 16'h03B5, "frozen total");
        check(16'(wide), 16'h0000, "frozen config");
        // Read view for every defined code, left justify in both widths
        for (int s = 0; s < 6; s++) begin
            w = (s < 5);
            code = (s < 5) ? 3'(s) : 3'h4;
            wr(ACC_CFG_ADDR, {w, 1'b0, code, 3'b000});
            rd(RESULT_LO_ADDR, lo);
            rd(RESULT_HI_ADDR, hi);
            check({hi, lo}, (code < 4) ? 16'h03B5 >> code
                  : (w ? 16'h03B5 << 4 : 16'h03B5 << 6), "read view");
        end
        check(total, 16'h03B5, "stored total unformatted");
        $display("Test accumulate done");
        // Burst off: power and go track the enable alone
        for (int e = 0; e < 2; e++) begin
            @(negedge clk_i);
            conv_en = 1'(e);
            #1;
            check(16'(pwr), 16'(e), "power follows enable");
            check(16'(go), 16'(e), "go follows enable");
        end
        // Burst with enable set: no wake delay, repeat codes 0 to 5
        @(negedge clk_i);
        burst = 1'b1;
        for (int r = 0; r < 6; r++) begin
            wr(ACC_CFG_ADDR, 8'(r));
            soc_wait(n);
            check(16'(n), 16'h0000, "no wake when enabled");
            repeat (cnt[r]) conv1(12'h002);
            @(negedge clk_i);
            check(16'(busy), 16'h0000, "burst finished");
            check(total, 16'(2 * cnt[r]), "burst sum");
            check(16'(pwr), 16'h0001, "stays powered");
        end
        $display("Test burst counts done");
        // Burst with enable clear: sleep, then wake after the set delay
        @(negedge clk_i);
        conv_en = 1'b0;
        // Four conversions per burst, so the repeat code must say so
        wr(ACC_CFG_ADDR, 8'h01);
        for (int f = 0; f < 2; f++) begin
            wr(PWR_TIME_ADDR, 8'(f));
            #1;
            check(16'(pwr), 16'h0000, "asleep when idle");
            soc_wait(n);
            check(16'(n), 16'((f + 1) * 400 / 20), "wake delay");
            repeat (4) conv1(12'h001);
            @(negedge clk_i);
            check(16'(busy), 16'h0000, "burst finished");
            check(16'(pwr), 16'h0000, "back to sleep");
            check(total, 16'h0004, "burst sum");
        end
        $display("Test low power done");
        give_verdict();
    end
endmodule
